// >>> design/tms_pkg.sv
// Purpose: shared constants and carriers of the measurement sequencer
// Assumes: apb slave with 8-bit byte addresses and 32-bit data
// Notes:   one aligned word per register, narrow data in the low bits
package tms_pkg;

    // ==========================================================
    // bus carriers
    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } tms_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tms_apb_rsp_t;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFF_SETUP_A   = 8'h00;
    localparam logic [7:0] OFF_SETUP_B   = 8'h04;
    localparam logic [7:0] OFF_IRQ_STS   = 8'h08;
    localparam logic [7:0] OFF_IRQ_MSK   = 8'h0C;
    localparam logic [7:0] OFF_CRS_OVF   = 8'h10;
    localparam logic [7:0] OFF_CLK_OVF   = 8'h14;
    localparam logic [7:0] OFF_HOLDOFF   = 8'h18;
    localparam logic [7:0] OFF_FINE_BASE = 8'h40;
    localparam logic [7:0] OFF_CYC_BASE  = 8'h60;
    localparam logic [7:0] OFF_CAL_ONE   = 8'h78;
    localparam logic [7:0] OFF_CAL_MULTI = 8'h7C;

    // ==========================================================
    // field positions
    localparam int A_GO         = 0;
    localparam int A_MODE_LSB   = 1;
    localparam int A_START_EDGE = 3;
    localparam int A_STOP_EDGE  = 4;
    localparam int A_TRIG_EDGE  = 5;
    localparam int A_PARITY     = 6;
    localparam int A_FORCE_CAL  = 7;
    localparam int B_NSTOP_LSB  = 0;
    localparam int B_AVG_LSB    = 3;
    localparam int B_CALWIN_LSB = 6;
    localparam int STS_DONE     = 0;
    localparam int STS_CRS_OVF  = 1;
    localparam int STS_CLK_OVF  = 2;
    localparam int STS_BUSY     = 3;

    // ==========================================================
    // reset values and encodings
    localparam logic [7:0]  RST_SETUP_A = 8'h00;
    localparam logic [7:0]  RST_SETUP_B = 8'h40;
    localparam logic [7:0]  RST_IRQ_MSK = 8'h07;
    localparam logic [15:0] RST_CRS_OVF = 16'hFFFF;
    localparam logic [15:0] RST_CLK_OVF = 16'hFFFF;
    localparam logic [15:0] RST_HOLDOFF = 16'h0000;
    localparam logic [1:0]  MODE_TWO    = 2'h1;
    localparam int          NUM_FINE    = 6;
    localparam int          NUM_CYC     = 5;
    localparam logic [2:0]  MAX_STOPS   = 3'h5;
    localparam logic [7:0]  CAL_WIN_0   = 8'h02;
    localparam logic [7:0]  CAL_WIN_1   = 8'h0A;
    localparam logic [7:0]  CAL_WIN_2   = 8'h14;
    localparam logic [7:0]  CAL_WIN_3   = 8'h28;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TRIG,
        ST_WAIT_START,
        ST_COUNT,
        ST_CAL,
        ST_FIN
    } tms_state_t;

endpackage // tms_pkg

// >>> design/tms_sequencer.sv
// Purpose: trigger/start/stop sequencer of a stopwatch time converter
// Assumes: start_i, stop_i and fine codes synchronous to clock_i;
//          nrst_i is the enable pin and resets all configuration
// Notes:   the analog delay line supplies fine_code_i and ring_rate_i
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
module tms_sequencer
    import tms_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire logic                  nrst_i,
    input  wire tms_pkg::tms_apb_req_t apb_i,
    output      tms_pkg::tms_apb_rsp_t apb_o,
    input  wire logic                  start_i,
    input  wire logic                  stop_i,
    input  wire logic [7:0]            fine_code_i,
    input  wire logic [15:0]           ring_rate_i,
    output      logic                  trigger_out_o,
    output      logic                  irq_n_o,
    output      logic                  irq_n_oe_o
);
    import tms_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        tms_state_t             st;
        logic [7:0]             setup_a;
        logic [7:0]             setup_b;
        logic [7:0]             sts;
        logic [7:0]             msk;
        logic [15:0]            crs_ovf;
        logic [15:0]            clk_ovf;
        logic [15:0]            holdoff;
        logic [5:0][23:0]       fine;
        logic [4:0][23:0]       cyc;
        logic [23:0]            cal_one;
        logic [23:0]            cal_multi;
        logic [23:0]            cnt;
        logic [2:0]             stops;
        logic [7:0]             avg_done;
        logic                   start_prev;
        logic                   stop_prev;
        logic                   trig;
        logic                   trig_pin;
        logic                   irq;
        logic                   irq_n;
        tms_apb_rsp_t           rsp;
    } tms_regs_t;

    tms_regs_t   q;
    tms_regs_t   d;

    logic        acc;
    logic        hit;
    logic        is_result;
    logic [23:0] rd_val;
    logic [31:0] wdat;
    logic        wr_fire;
    logic        mode_two;
    logic        start_edge;
    logic        stop_edge;
    logic [2:0]  nstops;
    logic [8:0]  avg_total;
    logic [7:0]  cal_win;
    logic [2:0]  idx;
    logic        last_stop;
    logic [39:0] prod;
    logic [NUM_FINE-1:0] fine_sel;
    logic [NUM_CYC-1:0]  cyc_sel;

    // ==========================================================
    // result slot address match, one comparator per slot
    for (genvar g = 0; g < NUM_FINE; g++) begin : g_fine_sel
        assign fine_sel[g] = (apb_i.paddr == OFF_FINE_BASE + 8'(4 * g));
    end
    for (genvar g = 0; g < NUM_CYC; g++) begin : g_cyc_sel
        assign cyc_sel[g] = (apb_i.paddr == OFF_CYC_BASE + 8'(4 * g));
    end

    // ==========================================================
    // next state
    always_comb begin
        d         = q;
        acc       = apb_i.psel & apb_i.penable;
        wdat      = apb_i.pwdata;
        hit       = 1'b1;
        is_result = 1'b0;
        rd_val    = 24'h000000;
        mode_two  = (q.setup_a[A_MODE_LSB +: 2] == MODE_TWO);
        idx       = 3'h0;
        last_stop = 1'b0;
        prod      = 40'h0000000000;

        // ==========================================================
        // read decode
        case (apb_i.paddr)
            OFF_SETUP_A: rd_val = {16'h0000, q.setup_a};
            OFF_SETUP_B: rd_val = {16'h0000, q.setup_b};
            OFF_IRQ_STS: rd_val = {16'h0000, q.sts};
            OFF_IRQ_MSK: rd_val = {16'h0000, q.msk};
            OFF_CRS_OVF: rd_val = {8'h00, q.crs_ovf};
            OFF_CLK_OVF: rd_val = {8'h00, q.clk_ovf};
            OFF_HOLDOFF: rd_val = {8'h00, q.holdoff};
            OFF_CAL_ONE: begin
                rd_val    = q.cal_one;
                is_result = 1'b1;
            end
            OFF_CAL_MULTI: begin
                rd_val    = q.cal_multi;
                is_result = 1'b1;
            end
            default: hit = 1'b0;
        endcase
        for (int i = 0; i < NUM_FINE; i++) begin
            if (fine_sel[i]) begin
                rd_val    = q.fine[i];
                hit       = 1'b1;
                is_result = 1'b1;
            end
        end
        for (int i = 0; i < NUM_CYC; i++) begin
            if (cyc_sel[i]) begin
                rd_val    = q.cyc[i];
                hit       = 1'b1;
                is_result = 1'b1;
            end
        end
        // even parity in the top bit of result words
        if (is_result && q.setup_a[A_PARITY]) begin
            rd_val[23] = ^rd_val[22:0];
        end

        // ==========================================================
        // apb answer one cycle into the access phase
        d.rsp.pready  = 1'b0;
        d.rsp.pslverr = 1'b0;
        if (acc && !q.rsp.pready) begin
            d.rsp.pready  = 1'b1;
            d.rsp.pslverr = !hit;
            d.rsp.prdata  = apb_i.pwrite ? 32'h00000000 : {8'h00, rd_val};
        end
        wr_fire = acc & q.rsp.pready & apb_i.pwrite & hit;

        // ==========================================================
        // register writes
        // settings persist
        if (wr_fire) begin
            case (apb_i.paddr)
                OFF_SETUP_A: begin
                    d.setup_a = wdat[7:0];
                    // a config write must not drop a running go bit
                    if (q.st != ST_IDLE) begin
                        d.setup_a[A_GO] = 1'b1;
                    end
                end
                OFF_SETUP_B: d.setup_b = wdat[7:0];
                // hardware sets below come after this clear and win
                OFF_IRQ_STS: d.sts = q.sts & ~wdat[7:0];
                OFF_IRQ_MSK: d.msk = wdat[7:0];
                OFF_CRS_OVF: d.crs_ovf = wdat[15:0];
                OFF_CLK_OVF: d.clk_ovf = wdat[15:0];
                OFF_HOLDOFF: d.holdoff = wdat[15:0];
                default: ;
            endcase
        end

        // ==========================================================
        // measurement start
        // go clears flags and results
        if (wr_fire && apb_i.paddr == OFF_SETUP_A && wdat[A_GO]
                && q.st == ST_IDLE) begin
            d.sts       = 8'h00;
            d.fine      = '0;
            d.cyc       = '0;
            d.cal_one   = 24'h000000;
            d.cal_multi = 24'h000000;
            d.avg_done  = 8'h00;
            d.st        = ST_TRIG;
        end

        // ==========================================================
        // edge detection with programmable polarity
        // idle pins at their reset level give no false edge
        start_edge = (start_i ^ q.setup_a[A_START_EDGE])
                   & !(q.start_prev ^ q.setup_a[A_START_EDGE]);
        stop_edge  = (stop_i ^ q.setup_a[A_STOP_EDGE])
                   & !(q.stop_prev ^ q.setup_a[A_STOP_EDGE]);
        d.start_prev = start_i;
        d.stop_prev  = stop_i;

        // ==========================================================
        // configuration decode
        nstops = (q.setup_b[B_NSTOP_LSB +: 3] >= 3'h4)
               ? MAX_STOPS : q.setup_b[B_NSTOP_LSB +: 3] + 3'h1;
        avg_total = 9'h001 << q.setup_b[B_AVG_LSB +: 3];
        case (q.setup_b[B_CALWIN_LSB +: 2])
            2'h0:    cal_win = CAL_WIN_0;
            2'h1:    cal_win = CAL_WIN_1;
            2'h2:    cal_win = CAL_WIN_2;
            default: cal_win = CAL_WIN_3;
        endcase

        // ==========================================================
        // measurement sequencer
        case (q.st)
            ST_IDLE: d.trig = 1'b0;
            ST_TRIG: begin
                d.trig = 1'b1;
                d.st   = ST_WAIT_START;
            end
            ST_WAIT_START: begin
                if (start_edge) begin
                    d.trig  = 1'b0;
                    // cycle count from next edge
                    // the first edge after start counts as cycle one
                    d.cnt   = 24'h000001;
                    d.stops = 3'h0;
                    if (mode_two) begin
                        d.fine[0] = q.fine[0] + 24'(fine_code_i);
                    end
                    d.st = ST_COUNT;
                end
            end
            ST_COUNT: begin
                d.cnt = q.cnt + 24'h000001;
                idx   = q.stops;
                if (stop_edge && q.cnt >= 24'(q.holdoff)) begin
                    // each stop in its own slot
                    d.stops   = q.stops + 3'h1;
                    last_stop = (q.stops + 3'h1 == nstops);
                    if (mode_two) begin
                        d.cyc[idx]          = q.cyc[idx] + q.cnt;
                        d.fine[idx + 3'h1]  = q.fine[idx + 3'h1]
                                            + 24'(fine_code_i);
                    end else begin
                        prod         = q.cnt * ring_rate_i;
                        d.fine[idx]  = q.fine[idx] + prod[23:0]
                                     + 24'(fine_code_i);
                    end
                    if (last_stop) begin
                        d.st = ST_CAL;
                    end
                end else if (mode_two && q.cnt > 24'(q.clk_ovf)) begin
                    d.sts[STS_CLK_OVF] = 1'b1;
                    d.st = q.setup_a[A_FORCE_CAL] ? ST_CAL : ST_FIN;
                end else if (!mode_two && q.cnt >= 24'(q.crs_ovf)) begin
                    d.sts[STS_CRS_OVF] = 1'b1;
                    d.st = q.setup_a[A_FORCE_CAL] ? ST_CAL : ST_FIN;
                end
            end
            ST_CAL: begin
                // calibration takes one cycle, derived from ring rate
                prod        = 40'(ring_rate_i) * 40'(cal_win);
                d.cal_one   = q.cal_one + 24'(ring_rate_i);
                d.cal_multi = q.cal_multi + prod[23:0];
                d.avg_done  = q.avg_done + 8'h01;
                if (9'(q.avg_done) + 9'h001 >= avg_total
                        || q.sts[STS_CRS_OVF] || q.sts[STS_CLK_OVF]) begin
                    d.st = ST_FIN;
                end else begin
                    d.st = ST_TRIG;
                end
            end
            ST_FIN: begin
                d.sts[STS_DONE]   = 1'b1;
                d.setup_a[A_GO]   = 1'b0;
                d.trig            = 1'b0;
                d.st              = ST_IDLE;
            end
            default: d.st = ST_IDLE;
        endcase

        // ==========================================================
        // status and pins
        d.sts[STS_BUSY] = (d.st != ST_IDLE);
        d.trig_pin      = d.trig ^ d.setup_a[A_TRIG_EDGE];
        d.irq           = |(d.sts[2:0] & d.msk[2:0]);
        d.irq_n         = !d.irq;
    end

    // ==========================================================
    // registers
    // enable low restores defaults
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q            <= '0;
            q.st         <= ST_IDLE;
            q.setup_a    <= RST_SETUP_A;
            q.setup_b    <= RST_SETUP_B;
            q.msk        <= RST_IRQ_MSK;
            q.crs_ovf    <= RST_CRS_OVF;
            q.clk_ovf    <= RST_CLK_OVF;
            q.holdoff    <= RST_HOLDOFF;
            q.irq_n      <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    assign apb_o         = q.rsp;
    assign trigger_out_o = q.trig_pin;
    // open drain: pin pulled low only while an interrupt is pending
    assign irq_n_o       = q.irq_n;
    assign irq_n_oe_o    = q.irq;

endmodule // tms_sequencer

// >>> test/tms_afe_model.sv
// Purpose: front end model answering each trigger with start and stops
// Assumes: edges are one-cycle rising pulses driven after a clock edge
// Notes:   fine code toggles outside pulses so stale values never match
module tms_afe_model (
    input  wire logic        clock_i,
    input  wire logic        trigger_i,
    input  wire logic [15:0] dly_i,
    input  wire logic [15:0] gap_i,
    input  wire logic [2:0]  nstop_i,
    input  wire logic [7:0]  fine_i,
    output      logic        start_o,
    output      logic        stop_o,
    output      logic [7:0]  fine_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int   cnt_q = -1;
    logic trig_q = 1'h0;
    int   k;
    initial begin
        start_o = 1'h0;
        stop_o  = 1'h0;
        fine_o  = 8'h5A;
    end
    always @(posedge clock_i) begin
        k = cnt_q - int'(dly_i);
        trig_q  <= trigger_i;
        start_o <= 1'h0;
        stop_o  <= 1'h0;
        fine_o  <= ~fine_o;
        cnt_q   <= (trigger_i && !trig_q) ? 0 : (cnt_q < 0 ? -1 : cnt_q + 1);
        if (k == 0) begin
            start_o <= 1'h1;
            fine_o  <= fine_i;
        end
        if (k > 0 && k % int'(gap_i) == 0 && k / int'(gap_i) <= nstop_i) begin
            stop_o <= 1'h1;
            fine_o <= fine_i + 8'(k / int'(gap_i));
        end
    end
endmodule // tms_afe_model

// >>> test/tms_sequencer_assertions.sv
// Purpose: port level checks of the measurement sequencer
// Assumes: edge polarities follow the last setup_a write
// Notes:   bound into every tms_sequencer instance
module tms_sequencer_assertions
    import tms_pkg::*;
(
    input wire logic                  clock_i,
    input wire logic                  nrst_i,
    input wire tms_pkg::tms_apb_req_t apb_i,
    input wire tms_pkg::tms_apb_rsp_t apb_o,
    input wire logic                  start_i,
    input wire logic                  stop_i,
    input wire logic [7:0]            fine_code_i,
    input wire logic [15:0]           ring_rate_i,
    input wire logic                  trigger_out_o,
    input wire logic                  irq_n_o,
    input wire logic                  irq_n_oe_o
);
    logic pol_t_q;
    logic pol_s_q;
    logic start_q;
    logic xfer;
    logic wr_a;
    logic trig_act;
    logic st_edge;
    assign xfer     = apb_i.psel && apb_i.penable && apb_o.pready;
    assign wr_a     = xfer && apb_i.pwrite && apb_i.paddr == OFF_SETUP_A;
    assign trig_act = trigger_out_o ^ pol_t_q;
    assign st_edge  = (start_i ^ pol_s_q) && !(start_q ^ pol_s_q);
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pol_t_q <= 1'h0;
            pol_s_q <= 1'h0;
            start_q <= 1'h0;
        end else begin
            start_q <= start_i;
            if (wr_a) begin
                pol_t_q <= apb_i.pwdata[A_TRIG_EDGE];
                pol_s_q <= apb_i.pwdata[A_START_EDGE];
            end
        end
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);
    sequence s_setup;
        apb_i.psel && !apb_i.penable;
    endsequence
    sequence s_wait;
        apb_i.psel && apb_i.penable && !apb_o.pready;
    endsequence
    sequence s_go;
        wr_a && apb_i.pwdata[A_GO] && !trig_act;
    endsequence
    AST_READY_LATENCY: assert property (s_setup ##1 s_wait |=> apb_o.pready)
        else $error("pready late");
    AST_READY_PULSE: assert property (apb_o.pready |=> !apb_o.pready)
        else $error("pready longer than one cycle");
    AST_ERR_ZERO: assert property (apb_o.pslverr |-> apb_o.pready
        && apb_o.prdata == 32'h0) else $error("bad error response");
    AST_GO_TRIGGER: assert property (s_go |-> ##2 trig_act)
        else $error("no trigger after go");
    AST_TRIG_HOLD: assert property (trig_act && !st_edge
        && !$past(st_edge) |=> trig_act) else $error("trigger lost early");
    AST_TRIG_DROP: assert property (st_edge && trig_act
        |-> ##[1:2] !trig_act) else $error("trigger kept after start");
    AST_IRQ_RESET: assert property ($rose(nrst_i) |-> irq_n_o
        && !irq_n_oe_o && !trigger_out_o) else $error("bad reset outputs");
    AST_IRQ_CLEAR: assert property ($fell(irq_n_oe_o)
        |-> $past(xfer && apb_i.pwrite) || $past(xfer && apb_i.pwrite, 2))
        else $error("interrupt dropped by itself");
    AST_NO_IRQ_TRIG: assert property (trig_act |-> !irq_n_oe_o)
        else $error("interrupt during series");
endmodule // tms_sequencer_assertions
bind tms_sequencer tms_sequencer_assertions tms_sequencer_assertions_inst (
    .clock_i(clock_i), .nrst_i(nrst_i), .apb_i(apb_i), .apb_o(apb_o),
    .start_i(start_i), .stop_i(stop_i), .fine_code_i(fine_code_i),
    .ring_rate_i(ring_rate_i), .trigger_out_o(trigger_out_o),
    .irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o));

// >>> test/tb_top.sv
// Purpose: self-checking bench of the measurement sequencer
// Assumes: default edge polarities, front end model on the pins
// Notes:   expected results come from the integer model in run_meas
module tb_top import tms_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clock_i = 1'h0;
    logic         nrst_i = 1'h0;
    logic         start_i, stop_i, trig, irq_n, irq_oe, err;
    logic [7:0]   fine_code, fine_b = 8'h00;
    logic [15:0]  rate = 16'h0100, dly = 16'h0003, gap = 16'h0002;
    logic [2:0]   nst = 3'h0;
    logic [31:0]  rd;
    tms_apb_req_t apb_i = '0;
    tms_apb_rsp_t apb_o;
    int           fail_count = 0, n_compared = 0, seed = 55181, trigs;
    int           md[5] = '{1, 0, 1, 1, 1}, ms[5] = '{5, 1, 2, 3, 1};
    int           sk[5] = '{0, 0, 1, 0, 0}, av[5] = '{0, 0, 1, 0, 7};
    tms_sequencer tms_sequencer_inst (.clock_i(clock_i), .nrst_i(nrst_i),
        .apb_i(apb_i), .apb_o(apb_o), .start_i(start_i), .stop_i(stop_i),
        .fine_code_i(fine_code), .ring_rate_i(rate),
        .trigger_out_o(trig), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe));
    tms_afe_model tms_afe_model_inst (.clock_i(clock_i), .trigger_i(trig),
        .dly_i(dly), .gap_i(gap), .nstop_i(nst), .fine_i(fine_b),
        .start_o(start_i), .stop_o(stop_i), .fine_o(fine_code));
    initial forever #25 clock_i = ~clock_i;
    always @(posedge trig) trigs++;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ==========================================================
    // bus and measurement tasks
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        apb_i.psel   <= 1'h1;
        apb_i.pwrite <= w;
        apb_i.paddr  <= a;
        apb_i.pwdata <= d;
        @(posedge clock_i);
        apb_i.penable <= 1'h1;
        do begin
            @(posedge clock_i);
        end while (apb_o.pready !== 1'h1);
        rd  = apb_o.prdata;
        err = apb_o.pslverr;
        apb_i.psel    <= 1'h0;
        apb_i.penable <= 1'h0;
        @(posedge clock_i);
    endtask
    task automatic defaults();
        logic [7:0]  a[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
        logic [31:0] v[7] = '{0, 32'h40, 0, 32'h07, 32'hFFFF, 32'hFFFF, 0};
        for (int i = 0; i < 7; i++) begin
            bus(1'h0, a[i], 0);
            check(rd, v[i]);
        end
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_oe !== 1'h1 && n < 20000) begin
            @(posedge clock_i);
            n++;
        end
        check(32'(irq_oe), 32'h1);
        check(32'(irq_n), 32'h0);
    endtask
    task automatic run_meas(input int two, input int m, input int skip,
                            input int avl);
        int c, j, e;
        c = 1 << avl;
        bus(1'h1, OFF_SETUP_B, 32'h40 | avl << 3 | (m - 1));
        bus(1'h1, OFF_HOLDOFF, skip * gap + 1);
        nst  <= 3'(m + skip);
        trigs = 0;
        bus(1'h1, OFF_SETUP_A, two << 1 | 1);
        wait_irq();
        check(trigs, c);
        for (int i = 0; i < 6; i++) begin
            j = skip + i + (two ^ 1);
            e = (two == 1) ? c * ((fine_b + (i > 0 ? j : 0)) % 256)
                           : c * ((fine_b + j) % 256 + j * gap * rate);
            bus(1'h0, OFF_FINE_BASE + 8'(4 * i), 0);
            check(rd, i < m + two ? e : 0);
        end
        for (int i = 0; i < 5 && two == 1; i++) begin
            bus(1'h0, OFF_CYC_BASE + 8'(4 * i), 0);
            check(rd >> avl, i < m ? (skip + i + 1) * gap : 0);
        end
        bus(1'h0, OFF_CAL_ONE, 0);
        check(rd, c * rate);
        bus(1'h0, OFF_CAL_MULTI, 0);
        check(rd, c * rate * 10);
        bus(1'h0, OFF_IRQ_STS, 0);
        check(32'(rd[3:0]), 32'h1);
        bus(1'h0, OFF_SETUP_A, 0);
        check(32'(rd[A_GO]), 32'h0);
        bus(1'h1, OFF_IRQ_STS, 32'h07);
        @(posedge clock_i);
        check(32'(irq_oe), 32'h0);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clock_i);
        nrst_i <= 1'h1;
        repeat (30000) @(posedge clock_i);
        rate   <= 16'($random(seed) & 32'hFFF);
        fine_b <= 8'($random(seed));
        defaults();
        bus(1'h0, 8'h30, 0);
        check(rd, 32'h0);
        check(32'(err), 32'h1);
        bus(1'h1, 8'h30, 32'hFFFFFFFF);
        check(32'(err), 32'h1);
        for (int t = 0; t < 5; t++) begin
            gap <= 16'(2 + $unsigned($random(seed)) % 8);
            dly <= t == 3 ? 16'h0190 : 16'(3 + $unsigned($random(seed)) % 40);
            @(posedge clock_i);
            run_meas(md[t], ms[t], sk[t], av[t]);
            bus(1'h0, OFF_SETUP_B, 0);
            check(rd, 32'h40 | av[t] << 3 | ms[t] - 1);
        end
        nst <= 3'h0;
        bus(1'h1, OFF_CLK_OVF, 32'h14);
        bus(1'h1, OFF_SETUP_A, 32'h03);
        wait_irq();
        bus(1'h0, OFF_IRQ_STS, 0);
        check(32'(rd[2:1]), 32'h2);
        bus(1'h1, OFF_CRS_OVF, 32'h14);
        bus(1'h1, OFF_SETUP_A, 32'h01);
        wait_irq();
        bus(1'h0, OFF_IRQ_STS, 0);
        check(32'(rd[2:1]), 32'h1);
        bus(1'h1, OFF_SETUP_A, 32'h03);
        repeat (8) @(posedge clock_i);
        nrst_i <= 1'h0;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'h1;
        @(posedge clock_i);
        defaults();
        conclude();
    end
    initial begin
        repeat (90000) @(posedge clock_i);
        fail_count++;
        conclude();
    end
endmodule // tb_top
